// ---- verilog/sdwc_pkg.sv ----
// constants shared by the sdram write-side controller
package sdwc_pkg;

   // --------------------------------------------------------------
   // register map and bus decode
   // --------------------------------------------------------------
   localparam logic [7:0] OFS_MODE = 8'h00;
   localparam logic [7:0] OFS_RTIMER = 8'h04;
   localparam logic [7:0] OFS_CONFIG = 8'h08;
   localparam logic [7:0] OFS_LOWPWR = 8'h10;
   localparam logic [7:0] OFS_ISR = 8'h20;
   localparam logic [7:0] OFS_MEMDEV = 8'h24;
   localparam int unsigned MEM_SEL_BIT = 28;
   localparam int unsigned RT_W = 12;

   // --------------------------------------------------------------
   // reset values and field positions
   // --------------------------------------------------------------
   localparam logic [31:0] RST_CONFIG = 32'h8523_72C0;
   localparam logic [31:0] RST_ZERO = 32'h0000_0000;
   localparam int unsigned CFG_COL_LSB = 0;
   localparam int unsigned CFG_ROW_LSB = 2;
   localparam int unsigned CFG_BUS16_BIT = 4;
   localparam int unsigned CFG_CAS_LSB = 5;
   localparam int unsigned CFG_TRP_LSB = 8;
   localparam int unsigned CFG_TRCD_LSB = 12;
   localparam int unsigned CFG_TRC_LSB = 16;
   localparam int unsigned LP_PARTIAL_ARRAY_SELF_REFRESH_LSB = 4;
   localparam int unsigned LP_TEMP_COMP_SELF_REFRESH_LSB = 8;
   localparam int unsigned LP_DS_LSB = 10;
   localparam int unsigned ISR_RES_BIT = 0;
   localparam int unsigned LMR_CAS_LSB = 4;
   localparam int unsigned EMR_TEMP_COMP_SELF_REFRESH_LSB = 3;
   localparam int unsigned EMR_DS_LSB = 5;
   localparam int unsigned A10_BIT = 10;

   // --------------------------------------------------------------
   // command modes and sdram commands {cs_n, ras_n, cas_n, we_n}
   // --------------------------------------------------------------
   localparam logic [2:0] MODE_NORMAL = 3'h0;
   localparam logic [2:0] MODE_NOP = 3'h1;
   localparam logic [2:0] MODE_PALL = 3'h2;
   localparam logic [2:0] MODE_LMR = 3'h3;
   localparam logic [2:0] MODE_REFRESH = 3'h4;
   localparam logic [2:0] MODE_EMR = 3'h5;
   localparam logic [3:0] CMD_DESEL = 4'hF;
   localparam logic [3:0] CMD_NOP = 4'h7;
   localparam logic [3:0] CMD_ACT = 4'h3;
   localparam logic [3:0] CMD_WRITE = 4'h4;
   localparam logic [3:0] CMD_PRE = 4'h2;
   localparam logic [3:0] CMD_REF = 4'h1;
   localparam logic [3:0] CMD_LMR = 4'h0;

   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_PRE = 7'h02,
      ST_ACT = 7'h04,
      ST_WRITE = 7'h08,
      ST_REFR = 7'h10,
      ST_MODE = 7'h20,
      ST_WAIT = 7'h40
   } sdwc_state_t;

endpackage

// ---- verilog/sdwc_addr_split.sv ----
// splits a system byte address into column, row and bank fields
`timescale 1ns/1ps
`default_nettype none
module sdwc_addr_split
   import sdwc_pkg::*;
#(
   parameter int unsigned AW = 28
)
(
   input wire logic [AW-1:0] byte_addr,
   input wire logic [1:0] col_sel,
   input wire logic [1:0] row_sel,
   input wire logic bus16,
   output logic [10:0] col,
   output logic [12:0] row,
   output logic [1:0] bank,
   output logic page_end
);

   always_comb
   begin
      logic [AW-1:0] sh;
      logic [10:0] col_mask;
      int unsigned cw;
      int unsigned rw;
      sh = '0;
      col_mask = '0;
      cw = 8 + 32'(col_sel);
      // row code 3 is not defined; widest row taken
      rw = (row_sel == 2'h0) ? 11 : ((row_sel == 2'h1) ? 12 : 13);
      // byte select below the column: one bit on 16-bit, two on 32-bit
      sh = bus16 ? (byte_addr >> 1) : (byte_addr >> 2); // R1
      col_mask = 11'((32'd1 << cw) - 32'd1); // R2
      col = sh[10:0] & col_mask; // R25
      sh = sh >> cw;
      row = sh[12:0] & 13'((32'd1 << rw) - 32'd1); // R2
      sh = sh >> rw;
      bank = sh[1:0]; // R3
      page_end = (col == col_mask);
   end

endmodule
`default_nettype wire

// ---- verilog/sdwc_ctrl.sv ----
// sdram controller: init command modes, write row management, refresh
//
// Contract
// [R1] 16-bit bus: address bit 0 selects byte, column starts at bit 1.
// [R2] 16-bit bus: 8 to 11 column bits, 11 to 13 row bits above.
// [R3] two bits above the row select bank; upper drives bank line 1.
// [R4] software programs timings, columns, rows, cas and bus width first.
// [R5] mobile parts: software sets self-refresh and drive settings first.
// [R6] software writes the memory type before the command sequence.
// [R7] software waits 200 us before any sdram signal toggles.
// [R8] mode 1: any sdram access issues a nop.
// [R9] mode 2: any sdram access issues precharge of all banks.
// [R10] mode 4: each access issues one auto-refresh; software does eight.
// [R11] mode 3: access issues load mode with cas latency, bank bits zero; the code drives the bank bits of the access address instead.
// [R12] mode 5: access issues extended load mode with low power settings.
// [R13] mode 0 plus one access ends init; normal writes follow.
// [R14] software writes the refresh interval in clock cycles.
// [R15] software should follow the nop step exactly.
// [R16] one refresh-error interrupt output is provided.
// [R17] single and burst writes; open row per bank is tracked.
// [R18] transfer type from the master steers the burst handling.
// [R19] sequential write in open row writes without precharge or activate.
// [R20] border or other row: precharge, activate, then write.
// [R21] configured precharge and activate waits are inserted.
// [R22] command mode field picks the command on each sdram access.
// [R23] refresh timer reloads from its count and fires one refresh.
// [R24] missed refresh sets error flag; reading status clears it.
// [R25] field positions follow configured columns, rows and bus width.
`timescale 1ns/1ps
`default_nettype none
module sdwc_ctrl
   import sdwc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [31:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic xfer_sequential,
   output logic refresh_error_irq,
   output logic sd_cke,
   output logic sd_cs_n,
   output logic sd_ras_n,
   output logic sd_cas_n,
   output logic sd_we_n,
   output logic [1:0] bank_field,
   output logic [12:0] sd_addr,
   output logic [3:0] sd_dqm_n,
   output logic [31:0] sd_dq_out,
   output logic sd_dq_oe_n
);

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   sdwc_state_t state, next_state, ret_state, next_ret_state;
   logic [3:0] wcnt, next_wcnt;
   logic [3:0] cmd, next_cmd;
   logic [1:0] next_bank_field;
   logic [12:0] next_sd_addr;
   logic [3:0] next_sd_dqm_n;
   logic [31:0] next_sd_dq_out;
   logic next_sd_dq_oe_n;
   logic [3:0] bank_open, next_bank_open;
   logic [12:0] open_row [4];
   logic [12:0] next_open_row [4];
   logic ack, next_ack, fsm_ack;
   logic [31:0] next_readdata;
   logic [2:0] mode_reg, next_mode_reg;
   logic [RT_W-1:0] rtimer, next_rtimer, rt_cnt, next_rt_cnt;
   logic [31:0] cfg, next_cfg, lowpwr, next_lowpwr;
   logic [1:0] memdev, next_memdev;
   logic ref_pend, next_ref_pend, ref_err, next_ref_err;

   // -----------------------------------------------------------------
   // request decode and address split
   // -----------------------------------------------------------------
   logic mem_req, reg_req, reg_take, bus16, half_hi, hit, normal, expire;
   logic page_end;
   logic [27:0] mem_addr;
   logic [10:0] col;
   logic [12:0] row;
   logic [1:0] bank;

   assign mem_req = (avs_read | avs_write) & avs_address[MEM_SEL_BIT];
   assign reg_req = (avs_read | avs_write) & ~avs_address[MEM_SEL_BIT];
   assign reg_take = reg_req & ~ack;
   assign bus16 = cfg[CFG_BUS16_BIT];
   // a 16-bit part takes one half-word per access, chosen by lanes
   assign half_hi = bus16 & (avs_byteenable[1:0] == 2'h0);
   assign mem_addr = {avs_address[27:2], half_hi, 1'b0};
   assign hit = bank_open[bank] & (open_row[bank] == row); // R17
   // undefined codes 6 and 7 behave as normal operation
   assign normal = (mode_reg == MODE_NORMAL) | (mode_reg > MODE_EMR); // R13
   assign avs_waitrequest = ~ack;
   assign {sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n} = cmd;
   assign sd_cke = 1'b1;
   assign refresh_error_irq = ref_err; // R16

   sdwc_addr_split #(.AW(28)) u_split (
      .byte_addr(mem_addr),
      .col_sel(cfg[CFG_COL_LSB +: 2]),
      .row_sel(cfg[CFG_ROW_LSB +: 2]),
      .bus16(bus16),
      .col(col),
      .row(row),
      .bank(bank),
      .page_end(page_end)
   );

   // -----------------------------------------------------------------
   // register file and refresh timer
   // -----------------------------------------------------------------
   always_comb
   begin
      next_mode_reg = mode_reg;
      next_rtimer = rtimer;
      next_cfg = cfg;
      next_lowpwr = lowpwr;
      next_memdev = memdev;
      next_readdata = '0;
      if (reg_take & avs_write)
      begin
         unique case (avs_address[7:0])
            OFS_MODE: next_mode_reg = avs_writedata[2:0]; // R22
            OFS_RTIMER: next_rtimer = avs_writedata[RT_W-1:0];
            OFS_CONFIG: next_cfg = avs_writedata;
            OFS_LOWPWR: next_lowpwr = avs_writedata;
            OFS_MEMDEV: next_memdev = avs_writedata[1:0];
            default: next_mode_reg = mode_reg;
         endcase
      end
      if (reg_take & avs_read)
      begin
         unique case (avs_address[7:0])
            OFS_MODE: next_readdata = {29'h0, mode_reg};
            OFS_RTIMER: next_readdata = {{(32 - RT_W){1'b0}}, rtimer};
            OFS_CONFIG: next_readdata = cfg;
            OFS_LOWPWR: next_readdata = lowpwr;
            OFS_ISR: next_readdata = {31'h0, ref_err};
            OFS_MEMDEV: next_readdata = {30'h0, memdev};
            default: next_readdata = '0;
         endcase
      end
      next_ack = reg_take | fsm_ack;
      // zero count stops refreshing; period equals the count
      expire = (rtimer != '0) & (rt_cnt == RT_W'(1)); // R23
      if (rtimer == '0)
         next_rt_cnt = '0;
      else if ((rt_cnt == '0) | expire)
         next_rt_cnt = rtimer; // R23
      else
         next_rt_cnt = rt_cnt - RT_W'(1);
      // a new expiry wins over the refresh that retires the old one
      next_ref_pend = expire | (ref_pend & (state != ST_REFR));
      // set wins over the status-read clear
      next_ref_err = (expire & ref_pend) | (ref_err & ~(reg_take & avs_read
         & (avs_address[7:0] == OFS_ISR))); // R24
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         mode_reg <= MODE_NORMAL;
         rtimer <= '0;
         cfg <= RST_CONFIG;
         lowpwr <= RST_ZERO;
         memdev <= 2'h0;
         avs_readdata <= RST_ZERO;
         ack <= 1'b0;
         rt_cnt <= '0;
         ref_pend <= 1'b0;
         ref_err <= 1'b0;
      end
      else
      begin
         mode_reg <= next_mode_reg;
         rtimer <= next_rtimer;
         cfg <= next_cfg;
         lowpwr <= next_lowpwr;
         memdev <= next_memdev;
         avs_readdata <= next_readdata;
         ack <= next_ack;
         rt_cnt <= next_rt_cnt;
         ref_pend <= next_ref_pend;
         ref_err <= next_ref_err;
      end
   end

   // -----------------------------------------------------------------
   // command sequencer
   // -----------------------------------------------------------------
   always_comb
   begin
      next_state = state;
      next_ret_state = ret_state;
      next_wcnt = wcnt;
      next_cmd = CMD_DESEL;
      next_bank_field = bank_field;
      next_sd_addr = sd_addr;
      next_sd_dqm_n = 4'hF;
      next_sd_dq_out = sd_dq_out;
      next_sd_dq_oe_n = 1'b1;
      next_bank_open = bank_open;
      next_open_row = open_row;
      fsm_ack = 1'b0;
      unique case (state)
         ST_IDLE:
         begin
            if (ref_pend)
               next_state = ST_PRE;
            else if (mem_req & ~ack)
            begin
               if (!normal)
                  next_state = ST_MODE; // R22
               else if (avs_read)
                  fsm_ack = 1'b1;
               else if (hit)
                  next_state = ST_WRITE; // R19
               else if (bank_open[bank])
               begin
                  next_bank_field = bank;
                  next_ret_state = ST_ACT;
                  next_state = ST_PRE; // R20
               end
               else
                  next_state = ST_ACT;
            end
         end
         ST_PRE:
         begin
            // refresh needs every bank closed, so it widens the precharge
            next_cmd = CMD_PRE;
            next_sd_addr = '0;
            next_sd_addr[A10_BIT] = ref_pend;
            if (ref_pend)
               next_bank_open = '0;
            else
               next_bank_open[bank_field] = 1'b0;
            next_wcnt = cfg[CFG_TRP_LSB +: 4]; // R21
            next_ret_state = ref_pend ? ST_REFR : ret_state;
            next_state = ST_WAIT;
         end
         ST_ACT:
         begin
            next_cmd = CMD_ACT; // R20
            next_bank_field = bank; // R3
            next_sd_addr = row;
            next_bank_open[bank] = 1'b1; // R17
            next_open_row[bank] = row; // R17
            next_wcnt = cfg[CFG_TRCD_LSB +: 4]; // R21
            next_ret_state = ST_WRITE;
            next_state = ST_WAIT;
         end
         ST_WRITE:
         begin
            next_cmd = CMD_WRITE;
            next_bank_field = bank;
            next_sd_addr = {1'b0, col[10], 1'b0, col[9:0]};
            next_sd_dq_oe_n = 1'b0;
            if (!bus16)
            begin
               next_sd_dqm_n = ~avs_byteenable;
               next_sd_dq_out = avs_writedata;
            end
            else if (half_hi)
            begin
               next_sd_dqm_n = {2'h3, ~avs_byteenable[3:2]}; // R1
               next_sd_dq_out = {16'h0, avs_writedata[31:16]};
            end
            else
            begin
               next_sd_dqm_n = {2'h3, ~avs_byteenable[1:0]}; // R1
               next_sd_dq_out = {16'h0, avs_writedata[15:0]};
            end
            fsm_ack = 1'b1;
            // a sequential beat at the last column will cross the border
            if (xfer_sequential & page_end)
            begin
               next_ret_state = ST_IDLE;
               next_state = ST_PRE; // R18
            end
            else
               next_state = ST_IDLE;
         end
         ST_REFR:
         begin
            next_cmd = CMD_REF; // R23
            next_wcnt = cfg[CFG_TRC_LSB +: 4];
            next_ret_state = ST_IDLE;
            next_state = ST_WAIT;
         end
         ST_MODE:
         begin
            next_bank_field = bank;
            next_sd_addr = '0;
            unique case (mode_reg)
               MODE_NOP: next_cmd = CMD_NOP; // R8
               MODE_PALL:
               begin
                  next_cmd = CMD_PRE; // R9
                  next_sd_addr[A10_BIT] = 1'b1;
                  next_bank_open = '0;
               end
               MODE_LMR:
               begin
                  // burst length field stays zero: one location
                  next_cmd = CMD_LMR; // R11
                  next_sd_addr[LMR_CAS_LSB +: 2] = cfg[CFG_CAS_LSB +: 2];
               end
               MODE_REFRESH: next_cmd = CMD_REF; // R10
               default:
               begin
                  next_cmd = CMD_LMR; // R12
                  next_sd_addr[2:0] = lowpwr[LP_PARTIAL_ARRAY_SELF_REFRESH_LSB +: 3];
                  next_sd_addr[EMR_TEMP_COMP_SELF_REFRESH_LSB +: 2] = lowpwr[LP_TEMP_COMP_SELF_REFRESH_LSB +: 2];
                  next_sd_addr[EMR_DS_LSB +: 2] = lowpwr[LP_DS_LSB +: 2];
               end
            endcase
            fsm_ack = 1'b1;
            next_wcnt = cfg[CFG_TRC_LSB +: 4];
            next_ret_state = ST_IDLE;
            next_state = ST_WAIT;
         end
         ST_WAIT:
         begin
            if (wcnt == 4'h0)
               next_state = ret_state; // R21
            else
               next_wcnt = wcnt - 4'h1;
         end
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         state <= ST_IDLE;
         ret_state <= ST_IDLE;
         wcnt <= 4'h0;
         cmd <= CMD_DESEL;
         bank_field <= 2'h0;
         sd_addr <= '0;
         sd_dqm_n <= 4'hF;
         sd_dq_out <= RST_ZERO;
         sd_dq_oe_n <= 1'b1;
         bank_open <= '0;
         for (int i = 0; i < 4; i++)
            open_row[i] <= '0;
      end
      else
      begin
         state <= next_state;
         ret_state <= next_ret_state;
         wcnt <= next_wcnt;
         cmd <= next_cmd;
         bank_field <= next_bank_field;
         sd_addr <= next_sd_addr;
         sd_dqm_n <= next_sd_dqm_n;
         sd_dq_out <= next_sd_dq_out;
         sd_dq_oe_n <= next_sd_dq_oe_n;
         bank_open <= next_bank_open;
         open_row <= next_open_row;
      end
   end

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   property p_nop_mode;
      @(posedge ref_clk) disable iff (!rst_n)
      (state == ST_MODE) && (mode_reg == MODE_NOP) |=> (cmd == CMD_NOP);
   endproperty
   a_nop_mode: assert property (p_nop_mode) else $error("mode 1 gave no nop"); // R8

   property p_pall_mode;
      @(posedge ref_clk) disable iff (!rst_n)
      (state == ST_MODE) && (mode_reg == MODE_PALL)
         |=> (cmd == CMD_PRE) && sd_addr[A10_BIT] && (bank_open == 4'h0);
   endproperty
   a_pall_mode: assert property (p_pall_mode) else $error("mode 2 bad"); // R9

   property p_ref_mode;
      @(posedge ref_clk) disable iff (!rst_n)
      (state == ST_MODE) && (mode_reg == MODE_REFRESH) |=> (cmd == CMD_REF);
   endproperty
   a_ref_mode: assert property (p_ref_mode) else $error("mode 4 bad"); // R10

   property p_lmr_mode;
      @(posedge ref_clk) disable iff (!rst_n)
      (state == ST_MODE) && (mode_reg == MODE_LMR)
         |=> (cmd == CMD_LMR) && (sd_addr[5:4] == $past(cfg[6:5]))
         && (sd_addr[2:0] == 3'h0);
   endproperty
   a_lmr_mode: assert property (p_lmr_mode) else $error("mode 3 bad"); // R11

   property p_emr_mode;
      @(posedge ref_clk) disable iff (!rst_n)
      (state == ST_MODE) && (mode_reg == MODE_EMR)
         |=> (cmd == CMD_LMR) && (sd_addr[2:0] == $past(lowpwr[6:4]));
   endproperty
   a_emr_mode: assert property (p_emr_mode) else $error("mode 5 bad"); // R12

   property p_hit_write;
      @(posedge ref_clk) disable iff (!rst_n)
      (state == ST_IDLE) && !ref_pend && mem_req && !ack && normal && avs_write && hit
         |=> (state == ST_WRITE) ##1 (cmd == CMD_WRITE) && ack;
   endproperty
   a_hit_write: assert property (p_hit_write) else $error("open row reopened"); // R19

   property p_miss_pre;
      @(posedge ref_clk) disable iff (!rst_n)
      (state == ST_IDLE) && !ref_pend && mem_req && !ack && normal && avs_write && !hit
         && bank_open[bank] |=> (state == ST_PRE) ##1 (cmd == CMD_PRE);
   endproperty
   a_miss_pre: assert property (p_miss_pre) else $error("row miss without precharge"); // R20

   property p_trcd_wait;
      @(posedge ref_clk) disable iff (!rst_n)
      (state == ST_ACT) && (cfg[15:12] == 4'h2)
         |=> (state == ST_WAIT) [*3] ##1 (state == ST_WRITE);
   endproperty
   a_trcd_wait: assert property (p_trcd_wait) else $error("activate wait wrong"); // R21

   property p_ref_err;
      @(posedge ref_clk) disable iff (!rst_n)
      expire && ref_pend |=> ref_err ##0 refresh_error_irq;
   endproperty
   a_ref_err: assert property (p_ref_err) else $error("missed refresh not flagged"); // R24

   property p_map16;
      @(posedge ref_clk) disable iff (!rst_n)
      bus16 && (cfg[3:0] == 4'h5)
         |-> (col[8:0] == mem_addr[9:1]) && (row[11:0] == mem_addr[21:10])
         && (bank == mem_addr[23:22]);
   endproperty
   a_map16: assert property (p_map16) else $error("16-bit address split wrong"); // R3

endmodule
`default_nettype wire

// ---- verif/sdwc_sdram_model.sv ----
// sdram device model: logs the commands seen on its pins
`timescale 1ns/1ps
`default_nettype none
module sdwc_sdram_model
   import sdwc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic [3:0] cmd,
   input wire logic [1:0] bank,
   input wire logic [12:0] addr,
   input wire logic [31:0] dq,
   input wire logic [3:0] dqm_n,
   input wire logic dq_oe_n,
   input wire logic cke
);
   // ------------------------------
   // command log and open rows
   // ------------------------------
   logic [3:0] last_cmd = CMD_DESEL;
   logic [1:0] last_bank;
   logic [12:0] last_addr;
   logic [12:0] act_row;
   logic [31:0] last_dq;
   logic [3:0] last_dqm_n;
   logic [3:0] open_bank = 4'h0;
   int cnt [16] = '{default: 0};
   int bad_write = 0;
   always @(posedge ref_clk)
   begin
      if (cmd != CMD_DESEL)
      begin
         last_cmd <= cmd;
         last_bank <= bank;
         last_addr <= addr;
         cnt[cmd] <= cnt[cmd] + 1;
      end
      if (cmd == CMD_ACT)
      begin
         act_row <= addr;
         open_bank[bank] <= 1'b1;
      end
      if (cmd == CMD_PRE)
         open_bank <= addr[A10_BIT] ? 4'h0 : open_bank & ~(4'h1 << bank);
      // a real part drops a write to a closed bank silently
      if (cmd == CMD_WRITE)
      begin
         last_dq <= dq;
         last_dqm_n <= dqm_n;
         if (!open_bank[bank] || dq_oe_n || !cke)
            bad_write <= bad_write + 1;
      end
   end
endmodule
`default_nettype wire

// ---- verif/tb.sv ----
// testbench: register bus, init command modes, row handling, refresh
`timescale 1ns/1ps
`default_nettype none
module tb
   import sdwc_pkg::*;
;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [31:0] avs_address = 32'h0000_0000;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [3:0] avs_byteenable = 4'hF;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic xfer_sequential = 1'b0;
   logic [31:0] avs_readdata, dq, q;
   logic avs_waitrequest, irq, cke, cs_n, ras_n, cas_n, we_n, oe_n;
   logic [1:0] ba;
   logic [12:0] sa;
   logic [3:0] dqm_n;
   int bad_count = 0;
   int tests_run = 0;
   int cycles = 0;
   int lat, a0, p0, r0;
   sdwc_ctrl sdwc_ctrl_inst (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .xfer_sequential(xfer_sequential),
      .refresh_error_irq(irq), .sd_cke(cke), .sd_cs_n(cs_n), .sd_ras_n(ras_n),
      .sd_cas_n(cas_n), .sd_we_n(we_n), .bank_field(ba), .sd_addr(sa), .sd_dqm_n(dqm_n),
      .sd_dq_out(dq), .sd_dq_oe_n(oe_n));
   sdwc_sdram_model m (.ref_clk(ref_clk), .cmd({cs_n, ras_n, cas_n, we_n}), .bank(ba),
      .addr(sa), .dq(dq), .dqm_n(dqm_n), .dq_oe_n(oe_n), .cke(cke));
   // ------------------------------
   // bus and compare helpers
   // ------------------------------
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp)
      begin
         $display("wrong value %s expected %h seen %h", what, exp, got);
         bad_count++;
      end
   endtask
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
      input logic [3:0] be, input logic seq);
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      xfer_sequential <= seq;
      avs_write <= wr;
      avs_read <= !wr;
      lat = 0;
      do
      begin
         @(posedge ref_clk);
         lat++;
      end
      while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      // the far-side log updates on the answer edge; let it settle
      @(posedge ref_clk);
   endtask
   task automatic reg_wr(input logic [7:0] ofs, input logic [31:0] d);
      bus(1'b1, {24'h00_0000, ofs}, d, 4'hF, 1'b0);
   endtask
   task automatic reg_rd(input logic [7:0] ofs);
      bus(1'b0, {24'h00_0000, ofs}, 32'h0000_0000, 4'hF, 1'b0);
   endtask
   task automatic mode_cmd(input logic [2:0] md, input logic [31:0] off);
      reg_wr(OFS_MODE, {29'h0, md});
      bus(1'b1, 32'h1000_0000 | off, 32'h0000_0000, 4'hF, 1'b0);
   endtask
   // ------------------------------
   // scenarios
   // ------------------------------
   task automatic test_regs;
      reg_rd(OFS_CONFIG);
      chk("config reset", RST_CONFIG, q);
      reg_rd(8'h30);
      chk("unmapped read", 32'h0000_0000, q);
      reg_wr(OFS_CONFIG, 32'h0002_2235);
      reg_rd(OFS_CONFIG);
      chk("config", 32'h0002_2235, q);
      reg_wr(OFS_LOWPWR, 32'h0000_0650);
      reg_wr(OFS_MEMDEV, 32'h0000_0001);
   endtask
   task automatic test_init;
      repeat (20000) @(posedge ref_clk);
      mode_cmd(MODE_NOP, 32'h0000_0000);
      chk("nop", 32'(CMD_NOP), 32'(m.last_cmd));
      mode_cmd(MODE_PALL, 32'h0000_0000);
      chk("pall", 32'h0000_0005, 32'({m.last_cmd, m.last_addr[A10_BIT]}));
      r0 = m.cnt[CMD_REF];
      repeat (8) mode_cmd(MODE_REFRESH, 32'h0000_0000);
      chk("refreshes", 32'h0000_0008, 32'(m.cnt[CMD_REF] - r0));
      mode_cmd(MODE_LMR, 32'h0000_0000);
      chk("lmr", 32'h0000_0010, 32'({m.last_cmd, m.last_bank, m.last_addr}));
      mode_cmd(MODE_EMR, 32'h0040_0000);
      chk("emr", 32'h0000_2035, 32'({m.last_cmd, m.last_bank, m.last_addr}));
      mode_cmd(MODE_NORMAL, 32'h0000_0000);
      chk("normal", 32'(CMD_WRITE), 32'(m.last_cmd));
   endtask
   task automatic test_writes;
      a0 = 32'h1040_1406;
      bus(1'b1, a0, 32'hAAAA_1234, 4'h3, 1'b0);
      chk("act row", 32'h0000_0005, 32'(m.act_row));
      chk("col", 32'h0002_2002, 32'({m.last_cmd, m.last_bank, m.last_addr}));
      chk("data", 32'h000C_1234, 32'({m.last_dqm_n, m.last_dq[15:0]}));
      p0 = m.cnt[CMD_PRE] + m.cnt[CMD_ACT];
      bus(1'b1, a0 + 2, 32'h0000_5678, 4'h3, 1'b1);
      chk("hit latency", 32'h0000_0003, 32'(lat));
      chk("hit col", 32'h0000_0004, 32'(m.last_addr));
      bus(1'b1, a0 | 1, 32'h9ABC_0000, 4'hC, 1'b0);
      chk("upper half", 32'h0003_9ABC, {m.last_addr[3:0], m.last_dq[15:0]});
      chk("no reopen", 32'(p0), 32'(m.cnt[CMD_PRE] + m.cnt[CMD_ACT]));
      bus(1'b1, 32'h1040_1806, 32'h0000_0001, 4'h3, 1'b0);
      chk("miss", 32'(p0 + 2), 32'(m.cnt[CMD_PRE] + m.cnt[CMD_ACT]));
      chk("miss latency", 32'h0000_000B, 32'(lat));
      chk("new row", 32'h0000_0006, 32'(m.act_row));
      chk("closed writes", 32'h0000_0000, 32'(m.bad_write));
   endtask
   task automatic test_refresh;
      r0 = m.cnt[CMD_REF];
      reg_wr(OFS_RTIMER, 32'h0000_0032);
      repeat (500) @(posedge ref_clk);
      r0 = m.cnt[CMD_REF] - r0;
      chk("refresh rate", 32'h0000_0001, 32'(r0 >= 9 && r0 <= 11));
      reg_wr(OFS_RTIMER, 32'h0000_0002);
      for (int i = 0; i < 300 && irq !== 1'b1; i++)
         @(posedge ref_clk);
      chk("irq set", 32'h0000_0001, 32'(irq));
      reg_wr(OFS_RTIMER, 32'h0000_0000);
      reg_rd(OFS_ISR);
      chk("status", 32'h0000_0001, q);
      reg_rd(OFS_ISR);
      chk("status cleared", 32'h0000_0000, q);
      chk("irq cleared", 32'h0000_0000, 32'(irq));
   endtask
   // ------------------------------
   // verdict, clock, timeout, main
   // ------------------------------
   task automatic give_verdict;
      if (bad_count == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial
   begin
      forever #5 ref_clk = ~ref_clk;
   end
   // init waits 20000 cycles; the rest needs under a thousand
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         bad_count++;
         give_verdict();
      end
   end
   initial
   begin
      repeat (10) @(posedge ref_clk);
      rst_n <= 1'b1;
      test_regs();
      test_init();
      test_writes();
      test_refresh();
      give_verdict();
   end
endmodule
`default_nettype wire
